// ===== include/pir_pkg.sv
// Purpose: Shared constants for the peripheral interrupt register block
// Assumes: Wishbone word index = printed offset, byte address = 4 * index
// Notes: Flag A and enable A have no bit 7; priority B uses bits 3..0 only
package pir_pkg;
	localparam int ADR_W = 18;
	localparam int DAT_W = 32;
	localparam int GRP_N = 6;
	// Register word indices
	localparam logic [15:0] IDX_PRIO_A = 16'hFF20;
	localparam logic [15:0] IDX_PRIO_B = 16'hFF21;
	localparam logic [15:0] IDX_EN_A = 16'hFF22;
	localparam logic [15:0] IDX_EN_B = 16'hFF23;
	localparam logic [15:0] IDX_FLAG_A = 16'hFF24;
	localparam logic [15:0] IDX_FLAG_B = 16'hFF25;
	// Values after reset
	localparam logic [7:0] RST_PRIO_A = 8'h00;
	localparam logic [3:0] RST_PRIO_B = 4'h0;
	localparam logic [6:0] RST_EN_A = 7'h00;
	localparam logic [7:0] RST_EN_B = 8'h00;
	localparam logic [0:0] RST_FLAG = 1'h0;
	// Group numbers, each group owns two bits of the packed priority vector
	localparam int G_KEYLO = 0;
	localparam int G_SERIAL = 1;
	localparam int G_STOPW = 2;
	localparam int G_CLOCKT = 3;
	localparam int G_PROGT = 4;
	localparam int G_KEYHI = 5;
	// Field positions in enable/flag register A
	localparam int B_SW_CENTI = 6;
	localparam int B_SW_DECI = 5;
	localparam int B_SW_SECOND = 4;
	localparam int B_CT_32HZ = 3;
	localparam int B_CT_8HZ = 2;
	localparam int B_CT_2HZ = 1;
	localparam int B_CT_1HZ = 0;
	// Field positions in enable/flag register B
	localparam int B_PT_ONE = 7;
	localparam int B_PT_ZERO = 6;
	localparam int B_KEY_HI = 5;
	localparam int B_KEY_UPPER = 4;
	localparam int B_KEY_LOWER = 3;
	localparam int B_SER_ERROR = 2;
	localparam int B_SER_RECEIVE = 1;
	localparam int B_SER_TRANSMIT = 0;
endpackage : pir_pkg

// ===== hw/pir_flag_bank.sv
// Purpose: Bank of sticky event flags, cleared by writing ones
// Assumes: Set and clear inputs are on the same clock as the flags
// Notes: A set in the clear cycle wins so no event is lost
`timescale 1ns/1ns
module pir_flag_bank #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Flag control
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	// Flag state
	output logic [W-1:0] flag_o
);
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_flag
			logic flag_r;
			logic flag_nxt;
			assign flag_nxt = set_i[g] | (flag_r & ~clr_i[g]);
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					flag_r <= pir_pkg::RST_FLAG[0];
				end else begin
					flag_r <= flag_nxt;
				end
			end
			assign flag_o[g] = flag_r;
		end
	endgenerate
endmodule : pir_flag_bank

// ===== hw/pir_top.sv
// Purpose: Priority, enable and factor flag registers for peripheral interrupts
// Assumes: Event inputs are one-cycle pulses from logic on clk_sys_i
// Notes: Classic Wishbone slave, ack one cycle after the strobe, writes land on the ack edge
`timescale 1ns/1ns
// Behaviour
// - Six source groups each have a 2-bit priority, code 11 is level 3, 00 level 0
// - Priority fields reset to zero, readable and writable, upper nibble of second reads zero
// - Stopwatch 100/10/1 Hz and clock timer 32/8/2/1 Hz enables, reset zero
// - Enables for timers one and zero, key groups and three serial causes, reset zero
// - Each source has a flag set by its event, reset to zero
// - Writing one clears a flag, writing zero leaves it
// - Separate flags for key nibbles low and high, one for keys ten and eleven
// - Separate serial error, receive and transmit flags, separate timer flags
module pir_top (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pir_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [pir_pkg::DAT_W-1:0] wb_dat_i,
	output logic [pir_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Peripheral event pulses
	input wire logic [6:0] evt_a_i,
	input wire logic [7:0] evt_b_i,
	// Interrupt request to the CPU
	output logic irq_o,
	output logic [1:0] irq_level_o,
	output logic [pir_pkg::GRP_N-1:0] irq_group_o
);
	logic ack_r;
	logic [7:0] rdat_r;
	logic [7:0] prio_a_r;
	logic [3:0] prio_b_r;
	logic [6:0] en_a_r;
	logic [7:0] en_b_r;
	logic irq_r;
	logic [1:0] lvl_r;
	logic [pir_pkg::GRP_N-1:0] grp_r;
	logic [6:0] flags_a;
	logic [7:0] flags_b;

	// Address decode
	wire [15:0] word_idx = wb_adr_i[pir_pkg::ADR_W-1:2];
	wire req = wb_cyc_i & wb_stb_i;
	wire hit_prio_a = (word_idx == pir_pkg::IDX_PRIO_A);
	wire hit_prio_b = (word_idx == pir_pkg::IDX_PRIO_B);
	wire hit_en_a = (word_idx == pir_pkg::IDX_EN_A);
	wire hit_en_b = (word_idx == pir_pkg::IDX_EN_B);
	wire hit_flag_a = (word_idx == pir_pkg::IDX_FLAG_A);
	wire hit_flag_b = (word_idx == pir_pkg::IDX_FLAG_B);
	wire [7:0] wdat8 = wb_dat_i[7:0];

	// Writes take effect only on the edge that sees ack, so a held request writes once
	wire wr = req & wb_we_i & ack_r & wb_sel_i[0];
	wire wr_prio_a = wr & hit_prio_a;
	wire wr_prio_b = wr & hit_prio_b;
	wire wr_en_a = wr & hit_en_a;
	wire wr_en_b = wr & hit_en_b;
	wire wr_flag_a = wr & hit_flag_a;
	wire wr_flag_b = wr & hit_flag_b;

	// Read mux; unmapped words and reserved bits read as zero
	logic [7:0] rmux;
	always_comb begin
		if (hit_prio_a) begin
			rmux = prio_a_r;
		end else if (hit_prio_b) begin
			rmux = {4'h0, prio_b_r};
		end else if (hit_en_a) begin
			rmux = {1'b0, en_a_r};
		end else if (hit_en_b) begin
			rmux = en_b_r;
		end else if (hit_flag_a) begin
			rmux = {1'b0, flags_a};
		end else if (hit_flag_b) begin
			rmux = flags_b;
		end else begin
			rmux = 8'h00;
		end
	end

	// Bus handshake: ack one cycle after the strobe, then dropped
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ack_r <= 1'b0;
			rdat_r <= 8'h00;
		end else begin
			ack_r <= req & ~ack_r;
			if (req & ~ack_r) begin
				rdat_r <= rmux;
			end
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = {24'h000000, rdat_r};

	// Priority and enable registers
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			prio_a_r <= pir_pkg::RST_PRIO_A;
			prio_b_r <= pir_pkg::RST_PRIO_B;
			en_a_r <= pir_pkg::RST_EN_A;
			en_b_r <= pir_pkg::RST_EN_B;
		end else begin
			if (wr_prio_a) begin
				prio_a_r <= wdat8;
			end
			if (wr_prio_b) begin
				prio_b_r <= wdat8[3:0];
			end
			if (wr_en_a) begin
				en_a_r <= wdat8[6:0];
			end
			if (wr_en_b) begin
				en_b_r <= wdat8;
			end
		end
	end

	// Factor flags, one cell per source
	pir_flag_bank #(
		.W(7)
	) u_flags_a (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.set_i(evt_a_i),
		.clr_i(wr_flag_a ? wdat8[6:0] : 7'h00),
		.flag_o(flags_a)
	);
	pir_flag_bank #(
		.W(8)
	) u_flags_b (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.set_i(evt_b_i),
		.clr_i(wr_flag_b ? wdat8 : 8'h00),
		.flag_o(flags_b)
	);

	// Pending sources and per-group requests
	wire [6:0] pend_a = flags_a & en_a_r;
	wire [7:0] pend_b = flags_b & en_b_r;
	wire [pir_pkg::GRP_N-1:0] grp_req;
	assign grp_req[pir_pkg::G_KEYLO] = pend_b[pir_pkg::B_KEY_UPPER] | pend_b[pir_pkg::B_KEY_LOWER];
	assign grp_req[pir_pkg::G_SERIAL] = |pend_b[pir_pkg::B_SER_ERROR:pir_pkg::B_SER_TRANSMIT];
	assign grp_req[pir_pkg::G_STOPW] = |pend_a[pir_pkg::B_SW_CENTI:pir_pkg::B_SW_SECOND];
	assign grp_req[pir_pkg::G_CLOCKT] = |pend_a[pir_pkg::B_CT_32HZ:pir_pkg::B_CT_1HZ];
	assign grp_req[pir_pkg::G_PROGT] = |pend_b[pir_pkg::B_PT_ONE:pir_pkg::B_PT_ZERO];
	assign grp_req[pir_pkg::G_KEYHI] = pend_b[pir_pkg::B_KEY_HI];

	// Group g owns bits 2g+1..2g
	wire [2*pir_pkg::GRP_N-1:0] prio_all = {prio_b_r[1:0], prio_b_r[3:2], prio_a_r[1:0],
		prio_a_r[3:2], prio_a_r[5:4], prio_a_r[7:6]};

	// Highest level among requesting groups; a level 0 request still raises irq
	wire [1:0] lvl_chain [0:pir_pkg::GRP_N];
	assign lvl_chain[0] = 2'h0;
	genvar g;
	generate
		for (g = 0; g < pir_pkg::GRP_N; g++) begin : g_lvl
			wire [1:0] gp = prio_all[2*g+1:2*g];
			assign lvl_chain[g+1] = (grp_req[g] && gp > lvl_chain[g]) ? gp : lvl_chain[g];
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_r <= 1'b0;
			lvl_r <= 2'h0;
			grp_r <= '0;
		end else begin
			irq_r <= |grp_req;
			lvl_r <= lvl_chain[pir_pkg::GRP_N];
			grp_r <= grp_req;
		end
	end
	assign irq_o = irq_r;
	assign irq_level_o = lvl_r;
	assign irq_group_o = grp_r;

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_ack_once;
		req && !ack_r |=> ack_r ##1 !ack_r;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");

	property p_prio_reset;
		@(posedge clk_sys_i) disable iff (1'b0)
		!rst_n_i |=> (prio_a_r == 8'h00 && prio_b_r == 4'h0 && en_a_r == 7'h00 && en_b_r == 8'h00);
	endproperty
	a_prio_reset: assert property (p_prio_reset) else $error("registers not zero after reset");

	property p_prio_b_read;
		req && !ack_r && !wb_we_i && hit_prio_b |=> wb_dat_o[7:4] == 4'h0 && wb_dat_o[3:0] == $past(prio_b_r);
	endproperty
	a_prio_b_read: assert property (p_prio_b_read) else $error("priority B read wrong");

	property p_en_write;
		wr_en_b |=> en_b_r == $past(wdat8) && en_a_r == $past(en_a_r);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable B write lost");

	property p_en_a_write;
		wr_en_a |=> en_a_r == $past(wdat8[6:0]);
	endproperty
	a_en_a_write: assert property (p_en_a_write) else $error("enable A write lost");

	property p_flag_set;
		evt_a_i[pir_pkg::B_CT_1HZ] |=> flags_a[pir_pkg::B_CT_1HZ] [*1];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

	property p_flag_w1c;
		wr_flag_b && evt_b_i == 8'h00 |=> flags_b == ($past(flags_b) & ~$past(wdat8));
	endproperty
	a_flag_w1c: assert property (p_flag_w1c) else $error("write-one-clear wrong");

	property p_set_wins;
		wr_flag_a && evt_a_i[pir_pkg::B_SW_CENTI] |=> flags_a[pir_pkg::B_SW_CENTI];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

	property p_key_split;
		evt_b_i == 8'h08 && flags_b == 8'h00 && !wr_flag_b |=> flags_b == 8'h08;
	endproperty
	a_key_split: assert property (p_key_split) else $error("key nibble flags not separate");

	property p_serial_split;
		evt_b_i == 8'h02 && flags_b == 8'h00 && !wr_flag_b |=> flags_b == 8'h02;
	endproperty
	a_serial_split: assert property (p_serial_split) else $error("serial flags not separate");

	property p_irq_cause;
		(|pend_a) || (|pend_b) |=> irq_o;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("pending source gave no irq");

	property p_irq_quiet;
		!(|pend_a) && !(|pend_b) |=> !irq_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without pending source");

	property p_level;
		grp_req == 6'h08 && prio_a_r[1:0] == 2'h3 |=> irq_level_o == 2'h3 && irq_group_o == 6'h08;
	endproperty
	a_level: assert property (p_level) else $error("clock timer level wrong");

	property p_ack_idle;
		!req |=> !ack_r;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

	property p_prio_a_write;
		wr_prio_a |=> prio_a_r == $past(wdat8);
	endproperty
	a_prio_a_write: assert property (p_prio_a_write) else $error("priority A write lost");

	property p_prio_b_write;
		wr_prio_b |=> prio_b_r == $past(wdat8[3:0]);
	endproperty
	a_prio_b_write: assert property (p_prio_b_write) else $error("priority B write lost");

	property p_prio_hold;
		!wr_prio_a && !wr_prio_b |=> prio_a_r == $past(prio_a_r) && prio_b_r == $past(prio_b_r);
	endproperty
	a_prio_hold: assert property (p_prio_hold) else $error("priority changed without write");

	property p_en_hold;
		!wr_en_a && !wr_en_b |=> en_a_r == $past(en_a_r) && en_b_r == $past(en_b_r);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("enable changed without write");

	property p_flag_a_w1c;
		wr_flag_a && evt_a_i == 7'h00 |=> flags_a == ($past(flags_a) & ~$past(wdat8[6:0]));
	endproperty
	a_flag_a_w1c: assert property (p_flag_a_w1c) else $error("flag A write-one-clear wrong");

	property p_flag_hold_a;
		!wr_flag_a && evt_a_i == 7'h00 |=> flags_a == $past(flags_a);
	endproperty
	a_flag_hold_a: assert property (p_flag_hold_a) else $error("flag A changed without cause");

	property p_flag_hold_b;
		!wr_flag_b && evt_b_i == 8'h00 |=> flags_b == $past(flags_b);
	endproperty
	a_flag_hold_b: assert property (p_flag_hold_b) else $error("flag B changed without cause");

	property p_flag_set_a;
		evt_a_i != 7'h00 |=> (flags_a & $past(evt_a_i)) == $past(evt_a_i);
	endproperty
	a_flag_set_a: assert property (p_flag_set_a) else $error("event A did not set its flag");

	property p_flag_set_b;
		evt_b_i != 8'h00 |=> (flags_b & $past(evt_b_i)) == $past(evt_b_i);
	endproperty
	a_flag_set_b: assert property (p_flag_set_b) else $error("event B did not set its flag");

	property p_set_wins_b;
		wr_flag_b && evt_b_i != 8'h00 |=> (flags_b & $past(evt_b_i)) == $past(evt_b_i);
	endproperty
	a_set_wins_b: assert property (p_set_wins_b) else $error("event B lost under clear");

	property p_irq_none;
		grp_req == 6'h00 |=> irq_level_o == 2'h0 && irq_group_o == 6'h00;
	endproperty
	a_irq_none: assert property (p_irq_none) else $error("level or group without request");

	property p_group_keyhi;
		pend_b[pir_pkg::B_KEY_HI] |=> irq_group_o[pir_pkg::G_KEYHI];
	endproperty
	a_group_keyhi: assert property (p_group_keyhi) else $error("keys ten and eleven not grouped");

	property p_group_serial;
		|pend_b[pir_pkg::B_SER_ERROR:pir_pkg::B_SER_TRANSMIT] |=> irq_group_o[pir_pkg::G_SERIAL];
	endproperty
	a_group_serial: assert property (p_group_serial) else $error("serial group not requesting");

	property p_group_stopw;
		|pend_a[pir_pkg::B_SW_CENTI:pir_pkg::B_SW_SECOND] |=> irq_group_o[pir_pkg::G_STOPW];
	endproperty
	a_group_stopw: assert property (p_group_stopw) else $error("stopwatch group not requesting");

	property p_level_keylo;
		grp_req[pir_pkg::G_KEYLO] |=> irq_level_o >= $past(prio_a_r[7:6]);
	endproperty
	a_level_keylo: assert property (p_level_keylo) else $error("key low level below its priority");

	property p_level_keyhi;
		grp_req[pir_pkg::G_KEYHI] |=> irq_level_o >= $past(prio_b_r[1:0]);
	endproperty
	a_level_keyhi: assert property (p_level_keyhi) else $error("key high level below its priority");

	property p_sel_ignore;
		req && wb_we_i && ack_r && !wb_sel_i[0] && hit_prio_a |=> prio_a_r == $past(prio_a_r);
	endproperty
	a_sel_ignore: assert property (p_sel_ignore) else $error("write without byte select landed");

	property p_rd_flag_a;
		req && !ack_r && !wb_we_i && hit_flag_a |=> wb_dat_o[7:0] == {1'b0, $past(flags_a)};
	endproperty
	a_rd_flag_a: assert property (p_rd_flag_a) else $error("flag A read wrong");

	property p_rd_unmapped;
		req && !ack_r && !wb_we_i && !hit_prio_a && !hit_prio_b && !hit_en_a && !hit_en_b && !hit_flag_a
			&& !hit_flag_b |=> wb_dat_o == 32'h00000000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

endmodule : pir_top

// ===== verif/pir_evt_src.sv
// Purpose: Model of the peripheral event sources
// Assumes: Sources run on clk_sys_i and pulse for one cycle
// Notes: Lines fall back to 0 between pulses
`timescale 1ns/1ns
module pir_evt_src (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Trigger
	input wire logic go_i,
	input wire logic [14:0] pat_i,
	// Event pulses
	output logic [6:0] evt_a_o,
	output logic [7:0] evt_b_o
);
	// One pulse per go, so each go sets a flag once
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !go_i) begin
			{evt_a_o, evt_b_o} <= 15'h0000;
		end else begin
			{evt_a_o, evt_b_o} <= pat_i;
		end
	end
endmodule : pir_evt_src

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the interrupt register block
// Assumes: Ack one cycle after the request is taken
// Notes: Random values from a fixed seed
`timescale 1ns/1ns
module testbench;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic go = 1'b0;
	logic [pir_pkg::ADR_W-1:0] adr = 18'h00000;
	logic [3:0] sel = 4'hF;
	logic [pir_pkg::DAT_W-1:0] wdat = 32'h00000000;
	logic [pir_pkg::DAT_W-1:0] rdat;
	logic [14:0] pat = 15'h0000;
	logic [14:0] f;
	logic [6:0] ea;
	logic [7:0] eb;
	logic [7:0] q;
	logic [7:0] p;
	logic [7:0] m;
	logic ack;
	logic irq;
	logic [1:0] lvl;
	logic [5:0] grp;
	integer seed = 8189;
	int fails = 0;
	int n_checks = 0;
	int cyc_n = 0;
	pir_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .evt_a_i(ea), .evt_b_i(eb), .irq_o(irq), .irq_level_o(lvl),
		.irq_group_o(grp));
	pir_evt_src src (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .pat_i(pat),
		.evt_a_o(ea), .evt_b_o(eb));
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task wrap_up;
		if (fails == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// Whole run is well under this many cycles
	always @(posedge clk_sys_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fails++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [15:0] i, input logic [7:0] d = 8'h00, input logic [3:0] s = 4'hF);
		@(posedge clk_sys_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h000000, d};
		sel <= s;
		do begin
			@(posedge clk_sys_i);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task fire(input logic [14:0] v);
		@(posedge clk_sys_i);
		go <= 1'b1;
		pat <= v;
		@(posedge clk_sys_i);
		go <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask : fire
	task clr_all;
		wb(1'b1, 16'hFF24, 8'hFF);
		wb(1'b1, 16'hFF25, 8'hFF);
	endtask : clr_all
	function logic [7:0] rmask(input int i);
		return (i == 1) ? 8'h0F : (i == 2) ? 8'h7F : 8'hFF;
	endfunction : rmask
	function logic [1:0] lmax(input logic [1:0] a, input logic [1:0] b);
		return (a > b) ? a : b;
	endfunction : lmax
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, 16'hFF20 + i[15:0]);
			chk("reset", 8'h00, q);
			wb(1'b1, 16'hFF20 + i[15:0], 8'hFF);
			wb(1'b0, 16'hFF20 + i[15:0]);
			chk("ones", (i < 4) ? rmask(i) : 8'h00, q);
		end
		wb(1'b0, 16'hFF26);
		chk("unmapped", 8'h00, q);
		wb(1'b1, 16'hFF20, 8'h5A, 4'hE);
		wb(1'b0, 16'hFF20);
		chk("sel", 8'hFF, q);
		repeat (8) begin
			f = $random(seed);
			m = $random(seed);
			fire(f);
			wb(1'b0, 16'hFF24);
			chk("flag_a", {1'b0, f[14:8]}, q);
			wb(1'b0, 16'hFF25);
			chk("flag_b", f[7:0], q);
			wb(1'b1, 16'hFF25, m);
			wb(1'b0, 16'hFF25);
			chk("clear", f[7:0] & ~m, q);
			clr_all();
		end
		// Event pulse lands on the same edge as the clearing write
		fire(15'h7FFF);
		fork
			wb(1'b1, 16'hFF24, 8'hFF);
			fire(15'h4100);
		join
		wb(1'b0, 16'hFF24);
		chk("set_wins_a", 8'h41, q);
		fork
			wb(1'b1, 16'hFF25, 8'hFF);
			fire(15'h0081);
		join
		wb(1'b0, 16'hFF25);
		chk("set_wins_b", 8'h81, q);
		clr_all();
		fire(15'h0002);
		wb(1'b0, 16'hFF25);
		chk("serial_rx", 8'h02, q);
		clr_all();
		// Stopwatch 100 Hz stays disabled so it must never request
		wb(1'b1, 16'hFF22, 8'h01);
		wb(1'b1, 16'hFF23, 8'h08);
		repeat (8) begin
			p = $random(seed);
			f = $random(seed);
			f = f & 15'h0108;
			wb(1'b1, 16'hFF20, p);
			fire(f | 15'h4000);
			chk("irq", {7'h00, f != 15'h0000}, {7'h00, irq});
			chk("group", {4'h0, f[8], 2'b00, f[3]}, {2'b00, grp});
			chk("level", {6'h00, lmax(f[3] ? p[7:6] : 2'b00, f[8] ? p[1:0] : 2'b00)}, {6'h00, lvl});
			clr_all();
		end
		// Reset again in mid-run
		wb(1'b1, 16'hFF20, 8'hFF);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		wb(1'b0, 16'hFF20);
		chk("rst_again", 8'h00, q);
		wrap_up();
	end
endmodule : testbench
